/* File: logic/cbm_pkg.sv */
/*
  constants, codes and types for the carrier band modem serial side.
  assumes a 4x oscillator on the design clock; no other dependency.
*/
`default_nettype none
package cbm_pkg;
  localparam int unsigned REF_CLK_HZ = 25_000_000;
  localparam int unsigned SYM_W = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  // tx and rx clocks are the oscillator divided by four
  localparam logic [1:0] DIV_LAST = 2'h3;
  localparam logic [1:0] RX_FALL_PHASE = 2'h2;
  localparam logic [1:0] RX_ALIGN_PHASE = 2'h0;
  // mac symbols on both channels
  localparam logic [2:0] SYM_ZERO = 3'h0;
  localparam logic [2:0] SYM_ONE = 3'h1;
  localparam logic [2:0] SYM_NON_DATA = 3'h2;
  localparam logic [2:0] SYM_SILENCE = 3'h3;
  localparam logic [2:0] SYM_BAD = 3'h4;
  // management commands and responses
  localparam logic [2:0] CMD_RESET = 3'h1;
  localparam logic [2:0] CMD_TX_ENABLE = 3'h2;
  localparam logic [2:0] CMD_TX_DISABLE = 3'h3;
  localparam logic [2:0] CMD_LOOP_ENABLE = 3'h4;
  localparam logic [2:0] CMD_LOOP_DISABLE = 3'h5;
  localparam logic [2:0] RSP_IDLE = 3'h0;
  localparam logic [2:0] RSP_PHY_ERROR = 3'h7;
  // reset values
  localparam logic LOOPBACK_RST = 1'b1;
  localparam logic TX_ENABLE_RST = 1'b0;
  localparam logic [1:0] LINE_OFF = 2'h3;
  // timing
  localparam int unsigned JABBER_TIME_MS = 500;
  localparam int unsigned JABBER_CYCLES_DFLT = JABBER_TIME_MS * (REF_CLK_HZ / 1000);
  localparam logic [4:0] ACTIVITY_WINDOW = 5'h10;
  localparam int unsigned BLANK_SYMBOLS = 8;
  localparam logic [5:0] BLANK_CYCLES = 6'(BLANK_SYMBOLS * 4);

  typedef enum logic [1:0] {CBM_PH_OFF, CBM_PH_LOW, CBM_PH_HIGH} cbm_phys_t;
  typedef enum logic {CBM_MGMT, CBM_DATA} cbm_mode_t;
endpackage
`default_nettype wire

/* File: logic/cbm_fifo_if.sv */
/*
  valid/ready carrier between the symbol capture and the symbol fifo.
  assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface cbm_fifo_if #(parameter int unsigned WIDTH = 3);
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
  modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

/* File: logic/cbm_fifo.sv */
/*
  flip-flop fifo, width and depth set by parameters.
  assumes a synchronised active-low reset and a common clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
module cbm_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  cbm_fifo_if.store port
);
  import cbm_pkg::*;
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic do_push;
  logic do_pop;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign port.push_ready = !full;
  assign port.pop_valid = !empty;
  assign port.pop_data = mem[rd_ptr[AW-1:0]];
  assign do_push = ce_in && port.push_valid && !full;
  assign do_pop = ce_in && port.pop_ready && !empty;

  always_ff @(posedge ref_clk_in)
  begin
    if (do_push)
    begin
      mem[wr_ptr[AW-1:0]] <= port.push_data;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/cbm_top.sv */
/*
  serial request/indication side, transmit modulator, jabber and rx clock
  of the carrier band modem. assumes the analog front end delivers decoded
  receive symbols with a strobe and a carrier level, all on the 4x clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cbm_top #(
  parameter int unsigned JABBER_CYCLES = cbm_pkg::JABBER_CYCLES_DFLT
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [cbm_pkg::SYM_W-1:0] tx_request_symbols_in,
  input wire logic mgmt_select_n_in,
  input wire logic end_blanking_disable_n_in,
  input wire logic rx_carrier_in,
  input wire logic rx_strobe_in,
  input wire logic [cbm_pkg::SYM_W-1:0] rx_symbol_in,
  output logic tx_symbol_clock_out,
  output logic tx_fifo_ready_out,
  output logic recovered_rx_clock_out,
  output logic [cbm_pkg::SYM_W-1:0] rx_indication_symbols_out,
  output logic mgmt_indication_n_out,
  output logic [1:0] line_drive_pair_out,
  output logic line_amp_gate_out,
  output logic line_amp_gate_oe_out,
  output logic jabber_fault_out,
  output logic pump_up_n_out,
  output logic pump_down_n_out
);
  import cbm_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [1:0] tx_phase;
  logic tx_take;
  cbm_mode_t mode;
  logic data_mode;
  logic loopback;
  logic tx_enable;
  logic jabber;
  logic reset_cmd;
  logic [2:0] last_cmd;
  logic [2:0] cur_sym;
  logic line_lvl;
  logic next_lvl;
  cbm_phys_t phys;
  logic drive_on;
  logic drive_on_q;
  logic tx_edge;
  logic [4:0] idle_cnt;
  logic tx_active;
  logic [31:0] jabber_cnt;
  logic jabber_hit;
  logic [1:0] rx_phase;
  logic [1:0] next_rx_phase;
  logic receiving;
  logic rx_update;
  logic [2:0] rx_hold;
  logic rx_new;
  logic [2:0] rx_new_sym;
  logic [5:0] blank_cnt;
  logic blanking;

  cbm_fifo_if #(.WIDTH(SYM_W)) fifo_bus ();

  cbm_fifo #(.WIDTH(SYM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .resetn_in(rst_n),
    .ce_in(ce_in),
    .port(fifo_bus.store)
  );

  // release is synchronised, assertion of reset stays asynchronous
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_pipe <= 2'h0;
    end
    else if (ce_in)
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // oscillator divided by four; clock high in phases 0 and 1
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_phase <= 2'h0;
    end
    else if (ce_in)
    begin
      tx_phase <= tx_phase + 2'h1;
    end
  end
  assign tx_symbol_clock_out = ~tx_phase[1];
  // the edge that ends phase 3 is the rising edge of the transmit clock
  assign tx_take = ce_in && (tx_phase == DIV_LAST);

  assign data_mode = (mode == CBM_DATA);
  assign reset_cmd = tx_take && !mgmt_select_n_in && (tx_request_symbols_in == CMD_RESET);

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= CBM_MGMT;
    end
    else if (ce_in)
    begin
      if (jabber || jabber_hit)
      begin
        mode <= CBM_MGMT;
      end
      else if (tx_take)
      begin
        mode <= mgmt_select_n_in ? CBM_DATA : CBM_MGMT;
      end
    end
  end

  // management command decode; commands are idempotent so holding one is harmless
  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopback <= LOOPBACK_RST;
      tx_enable <= TX_ENABLE_RST;
      last_cmd <= RSP_IDLE;
    end
    else if (tx_take && !mgmt_select_n_in)
    begin
      last_cmd <= tx_request_symbols_in;
      unique case (tx_request_symbols_in)
        CMD_RESET:
        begin
          loopback <= LOOPBACK_RST;
          tx_enable <= TX_ENABLE_RST;
        end
        CMD_TX_ENABLE: tx_enable <= 1'b1;
        CMD_TX_DISABLE: tx_enable <= 1'b0;
        CMD_LOOP_ENABLE: loopback <= 1'b1;
        CMD_LOOP_DISABLE: loopback <= 1'b0;
        default: last_cmd <= tx_request_symbols_in;
      endcase
    end
  end

  // a full fifo drops the request symbol; the controller cannot be stalled
  assign fifo_bus.push_valid = tx_take && mgmt_select_n_in && !jabber;
  assign fifo_bus.push_data = tx_request_symbols_in;
  assign fifo_bus.pop_ready = tx_take && data_mode;
  assign tx_fifo_ready_out = fifo_bus.push_ready;

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_sym <= SYM_SILENCE;
    end
    else if (tx_take)
    begin
      cur_sym <= (data_mode && fifo_bus.pop_valid) ? fifo_bus.pop_data : SYM_SILENCE;
    end
  end

  // physical halves: one = HH, zero = LL, non-data = HL
  always_comb
  begin
    phys = CBM_PH_OFF;
    unique case (cur_sym)
      SYM_ONE: phys = CBM_PH_HIGH;
      SYM_ZERO: phys = CBM_PH_LOW;
      SYM_NON_DATA: phys = tx_phase[1] ? CBM_PH_LOW : CBM_PH_HIGH;
      default: phys = CBM_PH_OFF;
    endcase
  end

  // high tone toggles every quarter, low tone once per half: phase coherent
  always_comb
  begin
    next_lvl = line_lvl;
    unique case (phys)
      CBM_PH_HIGH: next_lvl = ~line_lvl;
      CBM_PH_LOW: next_lvl = tx_phase[0] ? line_lvl : ~line_lvl;
      CBM_PH_OFF: next_lvl = line_lvl;
    endcase
  end

  assign drive_on = data_mode && tx_enable && !loopback && !jabber && (phys != CBM_PH_OFF);
  assign tx_edge = drive_on && (next_lvl != line_lvl);

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_lvl <= 1'b0;
      drive_on_q <= 1'b0;
      line_drive_pair_out <= LINE_OFF;
      line_amp_gate_out <= 1'b1;
    end
    else if (ce_in)
    begin
      line_lvl <= next_lvl;
      drive_on_q <= drive_on;
      line_drive_pair_out <= drive_on ? {next_lvl, ~next_lvl} : LINE_OFF;
      line_amp_gate_out <= !drive_on;
    end
  end
  // open collector: sinks only while the transmitter is enabled
  assign line_amp_gate_oe_out = ~line_amp_gate_out;

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_cnt <= ACTIVITY_WINDOW;
    end
    else if (ce_in)
    begin
      if (tx_edge)
      begin
        idle_cnt <= 5'h0;
      end
      else if (tx_take && (idle_cnt < ACTIVITY_WINDOW))
      begin
        idle_cnt <= idle_cnt + 5'h1;
      end
    end
  end
  assign tx_active = (idle_cnt < ACTIVITY_WINDOW);

  // digital stand-in for the charging capacitor; idle discharges it fully
  assign jabber_hit = ce_in && tx_active && (jabber_cnt == 32'(JABBER_CYCLES - 1));

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jabber_cnt <= 32'h0;
      jabber <= 1'b0;
    end
    else if (ce_in)
    begin
      jabber_cnt <= (tx_active && !jabber_hit) ? jabber_cnt + 32'h1 : 32'h0;
      if (jabber_hit)
      begin
        jabber <= 1'b1;
      end
      else if (reset_cmd)
      begin
        jabber <= 1'b0;
      end
    end
  end
  assign jabber_fault_out = jabber;

  // receive clock: free running on the oscillator, realigned by data strobes
  assign receiving = data_mode && !loopback && rx_carrier_in;
  always_comb
  begin
    next_rx_phase = rx_phase + 2'h1;
    if (receiving && rx_strobe_in)
    begin
      next_rx_phase = RX_ALIGN_PHASE;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_phase <= 2'h0;
      pump_up_n_out <= 1'b1;
      pump_down_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      rx_phase <= next_rx_phase;
      // early strobe pumps down, late strobe pumps up, on time neither
      pump_up_n_out <= !(receiving && rx_strobe_in && !rx_phase[1]);
      pump_down_n_out <= !(receiving && rx_strobe_in && (rx_phase == 2'h2));
    end
  end
  assign recovered_rx_clock_out = ~rx_phase[1];
  assign rx_update = ce_in && (rx_phase == 2'h1) && (next_rx_phase == RX_FALL_PHASE);

  // loopback feeds popped symbols straight back to the indication side
  assign rx_new = loopback ? fifo_bus.pop_ready && fifo_bus.pop_valid : receiving && rx_strobe_in;
  assign rx_new_sym = loopback ? fifo_bus.pop_data : rx_symbol_in;

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      blank_cnt <= 6'h0;
    end
    else if (ce_in)
    begin
      if (drive_on_q && !drive_on)
      begin
        blank_cnt <= BLANK_CYCLES;
      end
      else if (blank_cnt != 6'h0)
      begin
        blank_cnt <= blank_cnt - 6'h1;
      end
    end
  end
  assign blanking = (blank_cnt != 6'h0) && end_blanking_disable_n_in;

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_hold <= SYM_SILENCE;
      rx_indication_symbols_out <= RSP_IDLE;
      mgmt_indication_n_out <= 1'b0;
    end
    else if (ce_in)
    begin
      // a new symbol in the update cycle wins over the clear
      if (rx_new)
      begin
        rx_hold <= rx_new_sym;
      end
      else if (rx_update)
      begin
        rx_hold <= SYM_SILENCE;
      end
      if (rx_update)
      begin
        mgmt_indication_n_out <= data_mode;
        if (data_mode)
        begin
          rx_indication_symbols_out <= blanking ? SYM_SILENCE : rx_hold;
        end
        else
        begin
          rx_indication_symbols_out <= jabber ? RSP_PHY_ERROR : last_cmd;
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n || !ce_in);

  sequence tx_clk_cycle_s;
    tx_symbol_clock_out ##1 tx_symbol_clock_out ##1 !tx_symbol_clock_out ##1 !tx_symbol_clock_out;
  endsequence
  sequence cmd_seen_s;
    tx_take && !mgmt_select_n_in;
  endsequence

  tx_symbol_clock_div_a:
    assert property ((tx_phase == 2'h0) |-> tx_clk_cycle_s)
    else $error("transmit clock is not a divide by four");
  capture_edge_a:
    assert property (fifo_bus.push_valid |=> $rose(tx_symbol_clock_out))
    else $error("request captured off the transmit clock rise");
  select_mode_a:
    assert property (cmd_seen_s |-> !fifo_bus.push_valid ##1 !data_mode)
    else $error("command not treated as management");
  mode_ind_a:
    assert property (rx_update |=> (mgmt_indication_n_out == $past(data_mode)))
    else $error("mode indication disagrees with mode");
  ind_fall_a:
    assert property ($changed(rx_indication_symbols_out) |-> $fell(recovered_rx_clock_out))
    else $error("indication changed away from rx clock fall");
  osc_lock_a:
    assert property (!receiving |=> (rx_phase - $past(rx_phase)) == 2'h1)
    else $error("rx clock not free running");
  blank_hold_a:
    assert property ((rx_update && blanking && data_mode) |=> rx_indication_symbols_out == SYM_SILENCE)
    else $error("blanking did not report silence");
  silence_pair_a:
    assert property (!drive_on |=> line_drive_pair_out == LINE_OFF)
    else $error("line pair not high while off");
  gate_off_a:
    assert property (line_amp_gate_out |-> (line_drive_pair_out == LINE_OFF) && !line_amp_gate_oe_out)
    else $error("gate high with line driven");
  jabber_set_a:
    assert property (jabber_hit |=> jabber_fault_out [*2])
    else $error("jabber flag not raised on expiry");
  pump_excl_a:
    assert property (!pump_up_n_out |-> pump_down_n_out)
    else $error("pump up and down together");
  mgmt_tx_off_a:
    assert property (!data_mode |=> line_amp_gate_out)
    else $error("transmitter on in management mode");
  reset_loop_a:
    assert property (reset_cmd |=> loopback && !tx_enable)
    else $error("reset did not restore loopback");
  jabber_hold_a:
    assert property ((jabber && !reset_cmd) |=> jabber && !data_mode)
    else $error("jabber condition left without reset");
  idle_discharge_a:
    assert property ((!tx_active && !jabber) |=> jabber_cnt == 32'h0)
    else $error("jabber timer ran while idle");
endmodule
`default_nettype wire

/* File: testbench/cbm_mac_model.sv */
/*
  controller-side model of the serial request and indication channels.
  assumes the modem supplies both clocks; requests are queued by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module cbm_mac_model (
  input wire logic tx_symbol_clock_in,
  input wire logic recovered_rx_clock_in,
  input wire logic [cbm_pkg::SYM_W-1:0] rx_indication_symbols_in,
  input wire logic mgmt_indication_n_in,
  output logic [cbm_pkg::SYM_W-1:0] tx_request_symbols_out,
  output logic mgmt_select_n_out
);
  import cbm_pkg::*;
  logic [3:0] req_q[$];
  logic [2:0] rx_log[$];
  logic [2:0] ind_sym;
  logic ind_mode_n;
  initial
  begin
    tx_request_symbols_out = SYM_ZERO;
    mgmt_select_n_out = 1'b0;
  end
  // select bit on top, symbol or command below
  task automatic send(input logic sel_n, input logic [2:0] sym);
    req_q.push_back({sel_n, sym});
  endtask
  task automatic wait_idle();
    while (req_q.size() != 0)
      @(posedge tx_symbol_clock_in);
    @(posedge tx_symbol_clock_in);
  endtask
  // change just after the rise, sampled at the next one
  always @(posedge tx_symbol_clock_in)
  begin
    if (req_q.size() != 0)
      {mgmt_select_n_out, tx_request_symbols_out} <= req_q.pop_front();
    else if (mgmt_select_n_out)
      tx_request_symbols_out <= SYM_SILENCE;
  end
  // lines move on the fall, so the rise is a safe capture point
  always @(posedge recovered_rx_clock_in)
  begin
    ind_sym <= rx_indication_symbols_in;
    ind_mode_n <= mgmt_indication_n_in;
    if (mgmt_indication_n_in === 1'b1 && rx_indication_symbols_in !== SYM_SILENCE)
      rx_log.push_back(rx_indication_symbols_in);
  end
endmodule
`default_nettype wire

/* File: testbench/carrier_band_phy_serial_interface_bench.sv */
/*
  self-checking bench for the modem serial side with a controller model.
  assumes a shortened jabber count; one clock drives everything.
*/
`timescale 1ns/10ps
`default_nettype none
module carrier_band_phy_serial_interface_bench;
  import cbm_pkg::*;
  logic clk, resetn, blank_n, carrier, strobe;
  logic [2:0] rx_sym, req_sym, ind_sym;
  logic sel_n, tx_clk, fifo_rdy, rx_clk, mode_n, gate, gate_oe, jabber_fault, up_n, dn_n;
  logic [1:0] pair;
  logic prev;
  logic blank_n_vals[2] = '{1'b1, 1'b0};
  int err_count, num_checks, flips, pumps, gate_low;
  cbm_top #(.JABBER_CYCLES(200)) cbm_top_i (.ref_clk_in(clk), .resetn_in(resetn),
    .ce_in(1'b1), .tx_request_symbols_in(req_sym), .mgmt_select_n_in(sel_n),
    .end_blanking_disable_n_in(blank_n), .rx_carrier_in(carrier), .rx_strobe_in(strobe),
    .rx_symbol_in(rx_sym), .tx_symbol_clock_out(tx_clk), .tx_fifo_ready_out(fifo_rdy),
    .recovered_rx_clock_out(rx_clk), .rx_indication_symbols_out(ind_sym),
    .mgmt_indication_n_out(mode_n), .line_drive_pair_out(pair), .line_amp_gate_out(gate),
    .line_amp_gate_oe_out(gate_oe), .jabber_fault_out(jabber_fault), .pump_up_n_out(up_n),
    .pump_down_n_out(dn_n));
  cbm_mac_model cbm_mac_model_i (.tx_symbol_clock_in(tx_clk), .recovered_rx_clock_in(rx_clk),
    .rx_indication_symbols_in(ind_sym), .mgmt_indication_n_in(mode_n),
    .tx_request_symbols_out(req_sym), .mgmt_select_n_out(sel_n));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // line activity and pump pulses seen by the monitor
  always @(posedge clk)
  begin
    prev <= pair[1];
    if (pair[1] !== prev)
      flips <= flips + 1;
    if (up_n === 1'b0 || dn_n === 1'b0)
      pumps <= pumps + 1;
    if (gate === 1'b0)
      gate_low <= gate_low + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic flush();
    cbm_mac_model_i.wait_idle();
    tick(16);
  endtask
  task automatic cmd(input logic [2:0] c);
    cbm_mac_model_i.send(1'b0, c);
    flush();
  endtask
  task automatic data(input logic [2:0] s, input int n);
    repeat (n) cbm_mac_model_i.send(1'b1, s);
    flush();
  endtask
  task automatic rx_send(input logic [2:0] s);
    @(posedge clk);
    strobe <= 1'b1;
    rx_sym <= s;
    @(posedge clk);
    strobe <= 1'b0;
    rx_sym <= ~s;
    tick(2);
  endtask
  task automatic t_reset_state();
    check({pair, gate, gate_oe, jabber_fault, mode_n}, {2'h3, 4'b1000});
    check(fifo_rdy, 1'b1);
  endtask
  task automatic t_clocks();
    realtime t0;
    @(posedge tx_clk);
    t0 = $realtime;
    @(posedge tx_clk);
    check($rtoi($realtime - t0), 160);
    @(posedge rx_clk);
    t0 = $realtime;
    @(posedge rx_clk);
    check($rtoi($realtime - t0), 160);
  endtask
  task automatic t_commands();
    logic [2:0] list[5] = '{CMD_RESET, CMD_TX_DISABLE, CMD_LOOP_ENABLE, CMD_TX_ENABLE,
      CMD_LOOP_DISABLE};
    flips = 0;
    foreach (list[i])
    begin
      cmd(list[i]);
      check(cbm_mac_model_i.ind_sym, list[i]);
      check(cbm_mac_model_i.ind_mode_n, 1'b0);
    end
    check({flips != 0, gate}, 2'b01);
  endtask
  task automatic t_transmit();
    int f1;
    flips = 0;
    gate_low = 0;
    data(SYM_ONE, 8);
    f1 = flips;
    check(gate_low > 20, 1'b1);
    check(cbm_mac_model_i.ind_mode_n, 1'b1);
    flips = 0;
    data(SYM_ZERO, 8);
    check(f1 > flips && flips > 4, 1'b1);
    data(SYM_NON_DATA, 2);
    check({pair, gate, gate_oe}, 4'b1110);
  endtask
  task automatic t_loopback();
    logic [2:0] exp[4] = '{SYM_ONE, SYM_ZERO, SYM_NON_DATA, SYM_ONE};
    cmd(CMD_LOOP_ENABLE);
    cbm_mac_model_i.rx_log.delete();
    flips = 0;
    foreach (exp[i])
      cbm_mac_model_i.send(1'b1, exp[i]);
    flush();
    check(cbm_mac_model_i.rx_log.size(), 4);
    foreach (exp[i])
      if (cbm_mac_model_i.rx_log.size() > i)
        check(cbm_mac_model_i.rx_log[i], exp[i]);
    check(flips, 0);
  endtask
  task automatic t_receive();
    cmd(CMD_LOOP_DISABLE);
    data(SYM_SILENCE, 2);
    carrier <= 1'b1;
    cbm_mac_model_i.rx_log.delete();
    pumps = 0;
    rx_send(SYM_ZERO);
    rx_send(SYM_ONE);
    tick(1);
    rx_send(SYM_BAD);
    tick(12);
    check(cbm_mac_model_i.rx_log.size(), 3);
    check(pumps > 0, 1'b1);
    foreach (blank_n_vals[i])
    begin
      blank_n <= blank_n_vals[i];
      cbm_mac_model_i.send(1'b1, SYM_ONE);
      cbm_mac_model_i.wait_idle();
      tick(6);
      cbm_mac_model_i.rx_log.delete();
      rx_send(SYM_ZERO);
      tick(12);
      check(cbm_mac_model_i.rx_log.size(), {31'h0, ~blank_n_vals[i]});
    end
    carrier <= 1'b0;
    blank_n <= 1'b1;
    tick(40);
  endtask
  task automatic t_jabber();
    data(SYM_ONE, 80);
    check({jabber_fault, pair, gate}, 4'hf);
    check(cbm_mac_model_i.ind_sym, RSP_PHY_ERROR);
    check(cbm_mac_model_i.ind_mode_n, 1'b0);
    cmd(CMD_RESET);
    check(jabber_fault, 1'b0);
  endtask
  task automatic t_hard_reset();
    cmd(CMD_TX_ENABLE);
    cmd(CMD_LOOP_DISABLE);
    data(SYM_ONE, 20);
    @(posedge clk);
    resetn <= 1'b0;
    tick(3);
    t_reset_state();
    resetn <= 1'b1;
    tick(8);
    flips = 0;
    data(SYM_ONE, 4);
    check({flips != 0, gate}, 2'b01);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    resetn = 1'b0;
    blank_n = 1'b1;
    carrier = 1'b0;
    strobe = 1'b0;
    rx_sym = 3'h0;
    tick(10);
    t_reset_state();
    resetn <= 1'b1;
    tick(10);
    t_clocks();
    t_commands();
    t_transmit();
    t_loopback();
    t_receive();
    t_jabber();
    t_hard_reset();
    test_done();
  end
  // whole run is about a thousand cycles
  initial
  begin
    tick(30000);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
